// *** bia_core.sv ***
// Notes on behaviour
// - The read/write line is high for read cycles and low for write cycles.
// - The upper-byte enable goes low whenever the cycle touches an odd byte.
// - The latch strobe pulses while the address sits on the shared lines, for external latching.
// - The release grant goes low once a release request is taken and the hold state is entered.
// - The hold state lasts as long as the release request stays low.
// - The access is stretched for as long as the wait input stays low.
// - The data path is 16 bits wide with the width select low and 8 bits with it high.
// - The access strobe is low while the read or write is actually performed.
// - Addresses are 24 bits, covering 16 Mbytes.
// - The upper address byte is the bank number, 00 to FF, each bank 64 Kbytes.
// - Bank 0 addresses 80 to 87F are served by the internal 2048-byte RAM.
// - Bank 0 addresses 0 to 7F go to the internal peripheral registers.
`timescale 1ns/1ps
`default_nettype none

module bia_core #(
  parameter int STROBE_CYCLES = bia_pkg::STROBE_MIN_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire bia_pkg::bia_req_t req,
  output logic req_ready,
  output bia_pkg::bia_rsp_t rsp,
  output bia_pkg::bia_periph_t periph,
  input wire logic [15:0] periph_rdata,
  output logic [7:0] addr_lo_o,
  output logic [7:0] ad_mid_o,
  output logic ad_mid_oe,
  input wire logic [7:0] ad_mid_i,
  output logic [7:0] ad_hi_o,
  output logic ad_hi_oe,
  input wire logic [7:0] ad_hi_i,
  output logic ctrl_oe,
  output logic read_write,
  output logic upper_byte_enable_n,
  output logic addr_latch,
  output logic access_strobe_n,
  input wire logic ready_n_pin,
  input wire logic hold_req_n_pin,
  output logic bus_release_grant_n,
  input wire logic bus_width_8_pin
);

  // two-flop sampling of ready and data needs the minimum length
  if (STROBE_CYCLES < bia_pkg::STROBE_MIN_CYCLES ||
      STROBE_CYCLES >= (1 << bia_pkg::STROBE_CNT_W)) begin : g_bad_strobe
    $error("bia_core: strobe length out of range");
  end

  typedef struct packed {
    bia_pkg::bia_state_t state;
    logic [1:0] sync_rdy;
    logic [1:0] sync_hold;
    logic [1:0] sync_width;
    logic [7:0] sync_mid0;
    logic [7:0] sync_mid1;
    logic [7:0] sync_hi0;
    logic [7:0] sync_hi1;
    logic write;
    logic word;
    logic second;
    logic split;
    logic bus16;
    logic is_ram;
    logic [bia_pkg::ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic [bia_pkg::STROBE_CNT_W-1:0] cnt;
    bia_pkg::bia_rsp_t rsp;
    bia_pkg::bia_periph_t periph;
    logic ram_we;
    logic [1:0] ram_be;
    logic [7:0] addr_lo_o;
    logic [7:0] ad_mid_o;
    logic ad_mid_oe;
    logic [7:0] ad_hi_o;
    logic ad_hi_oe;
    logic ctrl_oe;
    logic read_write;
    logic ube_n;
    logic ale;
    logic strobe_n;
    logic grant_n;
  } bia_core_st_t;

  localparam bia_core_st_t RESET_ST = '{
    state: bia_pkg::ST_IDLE, sync_rdy: 2'h3, sync_hold: 2'h3, read_write: 1'h1,
    ube_n: 1'h1, strobe_n: 1'h1, grant_n: 1'h1, ctrl_oe: 1'h1, default: '0};

  bia_core_st_t cur;
  bia_core_st_t next_cur;
  logic [15:0] ram_rdata;
  logic [bia_pkg::RAM_IDX_W-1:0] ram_idx;
  logic [11:0] ram_off;

  // index of the word inside the internal RAM, realigned to even
  // taken from the next state so read data stand during the internal cycle
  assign ram_off = next_cur.addr[11:0] - bia_pkg::RAM_FIRST[11:0];
  assign ram_idx = ram_off[bia_pkg::RAM_IDX_W:1];

  bia_ram u_ram (
    .clock(clock),
    .wr_en(cur.ram_we),
    .byte_en(cur.ram_be),
    .idx(ram_idx),
    .wdata(cur.wdata),
    .rdata(ram_rdata)
  );

  // byte address and data of the current bus cycle
  logic [bia_pkg::ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_byte;
  logic [7:0] rd_byte;
  logic hit_periph;
  logic hit_ram;
  logic wait_done;

  always_comb begin
    cyc_addr = cur.addr + {23'h000000, cur.second};
    cyc_byte = cur.second ? cur.wdata[15:8] : cur.wdata[7:0];
    rd_byte = (cur.bus16 && cyc_addr[0]) ? cur.sync_mid1 : cur.sync_hi1;
    // bank byte selects the internal bank
    hit_periph = (req.addr[23:16] == bia_pkg::BANK_INTERNAL) &&
                 (req.addr[15:0] <= bia_pkg::PERIPH_LAST);
    hit_ram = (req.addr[23:16] == bia_pkg::BANK_INTERNAL) &&
              (req.addr[15:0] >= bia_pkg::RAM_FIRST) && (req.addr[15:0] <= bia_pkg::RAM_LAST);
    // stretch while wait is low
    // full length needed: pin data reach the logic two cycles late
    wait_done = (cur.cnt >= bia_pkg::STROBE_CNT_W'(STROBE_CYCLES)) && cur.sync_rdy[1];
  end

  assign req_ready = cur.state == bia_pkg::ST_IDLE && cur.sync_hold[1];

  always_comb begin
    next_cur = cur;
    next_cur.sync_rdy = {cur.sync_rdy[0], ready_n_pin};
    next_cur.sync_hold = {cur.sync_hold[0], hold_req_n_pin};
    next_cur.sync_width = {cur.sync_width[0], bus_width_8_pin};
    next_cur.sync_mid0 = ad_mid_i;
    next_cur.sync_mid1 = cur.sync_mid0;
    next_cur.sync_hi0 = ad_hi_i;
    next_cur.sync_hi1 = cur.sync_hi0;
    next_cur.rsp.done = 1'b0;
    next_cur.periph.sel = 1'b0;
    next_cur.ram_we = 1'b0;
    next_cur.ale = 1'b0;
    next_cur.strobe_n = 1'b1;
    case (cur.state)
      bia_pkg::ST_IDLE: begin
        next_cur.ad_mid_oe = 1'b0;
        next_cur.ad_hi_oe = 1'b0;
        if (!cur.sync_hold[1]) begin
          // grant only once hold is entered
          next_cur.state = bia_pkg::ST_HOLD;
          next_cur.grant_n = 1'b0;
          next_cur.ctrl_oe = 1'b0;
        end else if (req.valid) begin
          next_cur.write = req.write;
          next_cur.word = req.word;
          next_cur.addr = req.addr;
          next_cur.wdata = req.wdata;
          next_cur.second = 1'b0;
          next_cur.rsp.rdata = '0;
          // width select low means 16-bit path
          next_cur.bus16 = ~cur.sync_width[1];
          next_cur.split = req.word && (cur.sync_width[1] || req.addr[0]);
          if (hit_periph) begin
            next_cur.state = bia_pkg::ST_INTL;
            next_cur.is_ram = 1'b0;
            next_cur.periph = '{sel: 1'b1, write: req.write, word: req.word,
                                addr: req.addr[bia_pkg::PERIPH_ADDR_W-1:0], wdata: req.wdata};
          end else if (hit_ram) begin
            next_cur.state = bia_pkg::ST_INTL;
            next_cur.is_ram = 1'b1;
            next_cur.ram_we = req.write;
            next_cur.ram_be = req.word ? 2'h3 : (req.addr[0] ? 2'h2 : 2'h1);
            if (!req.word && req.addr[0]) next_cur.wdata = {req.wdata[7:0], req.wdata[7:0]};
          end else begin
            next_cur.state = bia_pkg::ST_ADDR;
          end
        end
      end
      bia_pkg::ST_ADDR: begin
        // latch strobe with address on lines
        next_cur.ale = 1'b1;
        next_cur.addr_lo_o = cyc_addr[7:0];
        next_cur.ad_mid_o = cyc_addr[15:8];
        next_cur.ad_hi_o = cyc_addr[23:16];
        next_cur.ad_mid_oe = 1'b1;
        next_cur.ad_hi_oe = 1'b1;
        // high for read, low for write
        next_cur.read_write = ~cur.write;
        next_cur.ube_n = ~(cyc_addr[0] || (cur.word && !cur.split));
        next_cur.cnt = '0;
        next_cur.state = bia_pkg::ST_STRB;
      end
      bia_pkg::ST_STRB: begin
        next_cur.strobe_n = 1'b0;
        // saturate so a long wait cannot wrap the count
        if (cur.cnt != '1) next_cur.cnt = cur.cnt + 1'b1;
        if (cur.bus16) begin
          next_cur.ad_mid_oe = cur.write;
          next_cur.ad_mid_o = (cur.word && !cur.split) ? cur.wdata[15:8] : cyc_byte;
        end
        next_cur.ad_hi_oe = cur.write;
        next_cur.ad_hi_o = (cur.word && !cur.split) ? cur.wdata[7:0] : cyc_byte;
        if (wait_done) begin
          next_cur.strobe_n = 1'b1;
          if (!cur.write) begin
            if (cur.word && !cur.split) next_cur.rsp.rdata = {cur.sync_mid1, cur.sync_hi1};
            else if (cur.second) next_cur.rsp.rdata[15:8] = rd_byte;
            else next_cur.rsp.rdata[7:0] = rd_byte;
          end
          if (cur.split && !cur.second) begin
            next_cur.second = 1'b1;
            next_cur.state = bia_pkg::ST_ADDR;
          end else begin
            next_cur.rsp.done = 1'b1;
            next_cur.state = bia_pkg::ST_IDLE;
          end
        end
      end
      bia_pkg::ST_INTL: begin
        // one cycle for the registered read of RAM or peripheral
        next_cur.rsp.done = 1'b1;
        if (cur.write) next_cur.rsp.rdata = '0;
        else if (!cur.is_ram) next_cur.rsp.rdata = periph_rdata;
        else if (!cur.word && cur.addr[0]) next_cur.rsp.rdata = {8'h00, ram_rdata[15:8]};
        else if (!cur.word) next_cur.rsp.rdata = {8'h00, ram_rdata[7:0]};
        else next_cur.rsp.rdata = ram_rdata;
        next_cur.state = bia_pkg::ST_IDLE;
      end
      bia_pkg::ST_HOLD: begin
        if (cur.sync_hold[1]) begin
          next_cur.state = bia_pkg::ST_IDLE;
          next_cur.grant_n = 1'b1;
          next_cur.ctrl_oe = 1'b1;
        end
      end
      default: next_cur = RESET_ST;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= RESET_ST;
    end else begin
      cur <= next_cur;
    end
  end

  assign rsp = cur.rsp;
  assign periph = cur.periph;
  assign addr_lo_o = cur.addr_lo_o;
  assign ad_mid_o = cur.ad_mid_o;
  assign ad_mid_oe = cur.ad_mid_oe;
  assign ad_hi_o = cur.ad_hi_o;
  assign ad_hi_oe = cur.ad_hi_oe;
  assign ctrl_oe = cur.ctrl_oe;
  assign read_write = cur.read_write;
  assign upper_byte_enable_n = cur.ube_n;
  assign addr_latch = cur.ale;
  assign access_strobe_n = cur.strobe_n;
  assign bus_release_grant_n = cur.grant_n;

endmodule // bia_core

`default_nettype wire

// *** bia_pkg.sv ***
package bia_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // bank 0 internal map
  localparam logic [7:0] BANK_INTERNAL = 8'h00;
  localparam logic [15:0] PERIPH_LAST = 16'h007F;
  localparam logic [15:0] RAM_FIRST = 16'h0080;
  localparam logic [15:0] RAM_LAST = 16'h087F;
  localparam int RAM_BYTES = 2048;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int RAM_IDX_W = $clog2(RAM_WORDS);
  localparam int PERIPH_ADDR_W = 7;

  // access strobe timing
  localparam int CLOCK_PERIOD_PS = 5000;
  localparam int STROBE_MIN_NS = 15;
  localparam int STROBE_MIN_CYCLES = (STROBE_MIN_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int STROBE_CNT_W = 4;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bia_req_t;

  typedef struct packed {
    logic done;
    logic [DATA_W-1:0] rdata;
  } bia_rsp_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic word;
    logic [PERIPH_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bia_periph_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_STRB = 5'h04,
    ST_INTL = 5'h08,
    ST_HOLD = 5'h10
  } bia_state_t;

endpackage

// *** bia_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

module bia_ram #(
  parameter int WORDS = bia_pkg::RAM_WORDS,
  parameter int IDX_W = bia_pkg::RAM_IDX_W
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [1:0] byte_en,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  if (WORDS > (1 << IDX_W)) begin : g_bad_idx
    $error("bia_ram: index too narrow");
  end

  // one array per byte lane so each lane has a single writer
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      logic [7:0] mem [WORDS];
      logic [7:0] q;
      always_ff @(posedge clock) begin
        if (wr_en && byte_en[g]) begin
          mem[idx] <= wdata[g*8 +: 8];
        end
        q <= mem[idx];
      end
    end
  endgenerate

  // registered read port
  assign rdata = {g_lane[1].q, g_lane[0].q};

endmodule // bia_ram

`default_nettype wire

// *** bia_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module bia_core_props (
  input wire logic clock,
  input wire logic sys_rst,
  input wire bia_pkg::bia_req_t req,
  input wire logic req_ready,
  input wire bia_pkg::bia_rsp_t rsp,
  input wire bia_pkg::bia_periph_t periph,
  input wire logic ctrl_oe,
  input wire logic ad_mid_oe,
  input wire logic ad_hi_oe,
  input wire logic read_write,
  input wire logic upper_byte_enable_n,
  input wire logic addr_latch,
  input wire logic access_strobe_n,
  input wire logic ready_n_pin,
  input wire logic hold_req_n_pin,
  input wire logic bus_release_grant_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic take;
  logic ext;
  assign take = req.valid && req_ready;
  assign ext = req.addr[23:16] != 8'h00 || req.addr[15:0] > 16'h087F;
  sequence s_int; !addr_latch ##1 rsp.done; endsequence
  sequence s_strb; !access_strobe_n [*3]; endsequence
  property p_rw; take && ext |-> ##2 addr_latch && read_write == !$past(req.write, 2); endproperty
  a_rw: assert property (p_rw) else $error("read_write or latch wrong");
  property p_ube; take && ext && req.addr[0] |-> ##2 !upper_byte_enable_n; endproperty
  a_ube: assert property (p_ube) else $error("upper byte enable high");
  property p_int; take && !ext |=> s_int; endproperty
  a_int: assert property (p_int) else $error("internal hit on bus");
  property p_per; take && req.addr[23:7] == 17'h0 |=> periph.sel && periph.addr == $past(req.addr[6:0]); endproperty
  a_per: assert property (p_per) else $error("peripheral strobe wrong");
  property p_strb; addr_latch |=> s_strb; endproperty
  a_strb: assert property (p_strb) else $error("access strobe short");
  // sync delay: three low samples fix the next decision
  property p_wait; (!access_strobe_n && !ready_n_pin) [*3] |=> !access_strobe_n; endproperty
  a_wait: assert property (p_wait) else $error("wait not honoured");
  property p_rel; hold_req_n_pin [*3] |=> bus_release_grant_n; endproperty
  a_rel: assert property (p_rel) else $error("grant kept after release");
  property p_grt; !bus_release_grant_n |-> !ctrl_oe && !ad_mid_oe && !ad_hi_oe && !req_ready; endproperty
  a_grt: assert property (p_grt) else $error("outputs driven in hold");
  property p_fell; $fell(bus_release_grant_n) |-> !$past(hold_req_n_pin, 3); endproperty
  a_fell: assert property (p_fell) else $error("grant without request");
endmodule // bia_core_props
bind bia_core bia_core_props bia_core_props_i (.clock, .sys_rst, .req, .req_ready, .rsp,
  .periph, .ctrl_oe, .ad_mid_oe, .ad_hi_oe, .read_write, .upper_byte_enable_n, .addr_latch,
  .access_strobe_n, .ready_n_pin, .hold_req_n_pin, .bus_release_grant_n);
`default_nettype wire

// *** bia_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bia_mem_model (
  input wire logic clock,
  input wire logic addr_latch,
  input wire logic access_strobe_n,
  input wire logic read_write,
  input wire logic upper_byte_enable_n,
  input wire logic width8,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] stall,
  output logic [15:0] rdata,
  output logic ready_n_pin
);
  // low address byte only; tests keep those distinct
  logic [7:0] mem [0:255];
  logic [7:0] a = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic [15:0] last = 16'h0000;
  logic [15:0] val;
  logic drv;
  assign val = width8 ? {~mem[a], mem[a]} : {mem[a | 8'h01], mem[a & 8'hFE]};
  assign drv = !access_strobe_n && read_write;
  assign ready_n_pin = cnt == 4'h0;
  // released lines show inverse, not a stale copy
  assign rdata = drv ? val : ~last;
  always @(posedge clock) begin
    if (drv) begin
      last = val;
    end
    if (addr_latch) begin
      a = bus_addr[7:0];
      cnt = stall;
    end else if (cnt != 4'h0) begin
      cnt = cnt - 4'h1;
    end
    if (!access_strobe_n && !read_write) begin
      if (width8) begin
        mem[a] = wdata[7:0];
      end else begin
        if (!a[0]) mem[a] = wdata[7:0];
        if (!upper_byte_enable_n) mem[a | 8'h01] = wdata[15:8];
      end
    end
  end
endmodule // bia_mem_model
`default_nettype wire

// *** tb_bia_core.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_bia_core;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hold_req_n_pin = 1'b1;
  logic bus_width_8_pin = 1'b0;
  logic [3:0] stall = 4'h0;
  logic [15:0] periph_rdata = 16'hA5C3;
  bia_pkg::bia_req_t req = '0;
  bia_pkg::bia_rsp_t rsp;
  bia_pkg::bia_periph_t periph;
  logic req_ready, ad_mid_oe, ad_hi_oe, ctrl_oe, read_write, upper_byte_enable_n;
  logic addr_latch, access_strobe_n, ready_n_pin, bus_release_grant_n;
  logic [7:0] addr_lo_o, ad_mid_o, ad_hi_o;
  logic [15:0] mrd, got;
  int n_errors = 0, compares = 0, latches = 0, cyc = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) if (addr_latch) latches++;
  bia_core bia_core_i (.clock, .sys_rst, .req, .req_ready, .rsp, .periph, .periph_rdata,
    .addr_lo_o, .ad_mid_o, .ad_mid_oe, .ad_mid_i(ad_mid_oe ? ad_mid_o : mrd[15:8]),
    .ad_hi_o, .ad_hi_oe, .ad_hi_i(ad_hi_oe ? ad_hi_o : mrd[7:0]), .ctrl_oe, .read_write,
    .upper_byte_enable_n, .addr_latch, .access_strobe_n, .ready_n_pin, .hold_req_n_pin,
    .bus_release_grant_n, .bus_width_8_pin);
  bia_mem_model bia_mem_model_i (.clock, .addr_latch, .access_strobe_n, .read_write,
    .upper_byte_enable_n, .width8(bus_width_8_pin), .bus_addr({ad_hi_o, ad_mid_o, addr_lo_o}),
    .wdata({ad_mid_o, ad_hi_o}), .stall, .rdata(mrd), .ready_n_pin);
  // cyc ends as the number of edges from take to done
  task automatic acc(input logic wr, input logic wd, input logic [23:0] ad,
    input logic [15:0] wv);
    int n = 0;
    @(negedge clock);
    req = '{1'b1, wr, wd, ad, wv};
    while (req_ready !== 1'b1 && n < 200) begin
      n++;
      @(negedge clock);
    end
    @(negedge clock);
    req.valid = 1'b0;
    cyc = 0;
    while (rsp.done !== 1'b1 && cyc < 200) begin
      cyc++;
      @(negedge clock);
    end
    got = rsp.rdata;
  endtask
  task automatic t_ext();
    latches = 0;
    acc(1'b1, 1'b1, 24'hFF0010, 16'h1234);
    acc(1'b1, 1'b0, 24'h012341, 16'h0056);
    acc(1'b0, 1'b1, 24'hFF0010, 16'h0000);
    `CHK("word", 16'h1234, got)
    `CHK("cycles", 5, cyc)
    acc(1'b0, 1'b0, 24'h012341, 16'h0000);
    `CHK("odd byte", 8'h56, got[7:0])
    `CHK("latches", 4, latches)
    $display("test ext done");
  endtask
  task automatic t_w8();
    bus_width_8_pin = 1'b1;
    repeat (3) @(negedge clock);
    latches = 0;
    acc(1'b1, 1'b1, 24'h020020, 16'hBEEF);
    `CHK("split", 2, latches)
    acc(1'b0, 1'b1, 24'h020020, 16'h0000);
    `CHK("w8 word", 16'hBEEF, got)
    bus_width_8_pin = 1'b0;
    repeat (3) @(negedge clock);
    $display("test w8 done");
  endtask
  task automatic t_int();
    latches = 0;
    acc(1'b1, 1'b1, 24'h000080, 16'h5AA5);
    acc(1'b1, 1'b1, 24'h00087E, 16'h0FF0);
    acc(1'b0, 1'b1, 24'h000080, 16'h0000);
    `CHK("ram lo", 16'h5AA5, got)
    `CHK("ram cyc", 1, cyc)
    acc(1'b0, 1'b1, 24'h00087E, 16'h0000);
    `CHK("ram hi", 16'h0FF0, got)
    acc(1'b0, 1'b1, 24'h00007E, 16'h0000);
    `CHK("periph", 16'hA5C3, got)
    `CHK("no bus", 0, latches)
    acc(1'b0, 1'b0, 24'h000880, 16'h0000);
    `CHK("past ram", 1, latches)
    $display("test int done");
  endtask
  task automatic t_wait();
    stall = 4'h6;
    acc(1'b0, 1'b1, 24'hFF0010, 16'h0000);
    `CHK("slow word", 16'h1234, got)
    `CHK("stretched", 1'b1, cyc >= 8)
    stall = 4'h0;
    $display("test wait done");
  endtask
  task automatic t_hold();
    hold_req_n_pin = 1'b0;
    repeat (5) @(negedge clock);
    `CHK("grant", 1'b0, bus_release_grant_n)
    `CHK("ctrl oe", 1'b0, ctrl_oe)
    `CHK("ready", 1'b0, req_ready)
    hold_req_n_pin = 1'b1;
    repeat (5) @(negedge clock);
    `CHK("regrant", 1'b1, bus_release_grant_n)
    `CHK("ctrl back", 1'b1, ctrl_oe)
    $display("test hold done");
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (3) @(negedge clock);
    `CHK("rw idle", 1'b1, read_write)
    t_ext();
    t_w8();
    t_int();
    t_wait();
    t_hold();
    results();
  end
  // tests need well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    results();
  end
endmodule // tb_bia_core
`default_nettype wire
